// *** design/ars_pkg.sv ***
// types shared by the channel-a range register bank
package ars_pkg;
    typedef enum logic [1:0] {
        ARS_RNG_10V,
        ARS_RNG_5V,
        ARS_RNG_2V5
    } ars_range_e;
    typedef logic [15:0] ars_word_t;
endpackage

// *** design/ars_range_bank.sv ***
// axi4-lite register bank holding the channel-a input range selections
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "ars_regs.svh"
module ars_range_bank #(
    parameter int ADDR_W = 8
) (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // decoded channel-a ranges
    output ars_pkg::ars_range_e range_chan_a_in0,
    output ars_pkg::ars_range_e range_chan_a_in1,
    output ars_pkg::ars_range_e range_chan_a_in2,
    output ars_pkg::ars_range_e range_chan_a_in3,
    output ars_pkg::ars_range_e range_chan_a_in4,
    output ars_pkg::ars_range_e range_chan_a_in5,
    output ars_pkg::ars_range_e range_chan_a_in6,
    output ars_pkg::ars_range_e range_chan_a_in7
);
    import ars_pkg::*;

    localparam int NCH = `ARS_NUM_REGS * `ARS_FIELDS_PER_REG;

    // range code to range
    function automatic ars_range_e decode_range(input logic [1:0] code);
        unique case (code)
            2'h1: decode_range = ARS_RNG_2V5;
            2'h2: decode_range = ARS_RNG_5V;
            default: decode_range = ARS_RNG_10V;
        endcase
    endfunction

    // byte address to register slot; bit 0 of hit is slot, bit 1 is valid
    function automatic logic [1:0] reg_slot(input logic [ADDR_W-1:0] addr);
        logic [5:0] idx;
        idx = 6'(addr >> 2);
        if (idx == `ARS_IDX_RANGE_A_LOW) begin
            reg_slot = 2'h2;
        end else if (idx == `ARS_IDX_RANGE_A_HIGH) begin
            reg_slot = 2'h3;
        end else begin
            reg_slot = 2'h0;
        end
    endfunction

    logic aw_held_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic w_held_q;
    logic [15:0] w_data_q;
    logic [1:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    ars_range_e range_q [NCH];
    ars_word_t reg_q [`ARS_NUM_REGS];

    wire aw_fire;
    wire w_fire;
    wire ar_fire;
    wire wr_go;
    wire [1:0] wr_slot;
    wire [1:0] rd_slot;
    wire [15:0] wr_mask;
    wire [31:0] rd_word;

    assign awready = ce && !aw_held_q && !bvalid_q;
    assign wready = ce && !w_held_q && !bvalid_q;
    assign arready = ce && !rvalid_q;
    assign aw_fire = awvalid && awready;
    assign w_fire = wvalid && wready;
    assign ar_fire = arvalid && arready;
    assign wr_go = ce && aw_held_q && w_held_q && !bvalid_q;
    assign wr_slot = reg_slot(aw_addr_q);
    assign rd_slot = reg_slot(araddr);
    assign wr_mask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    // whole word stored, reserved bit 8 included, address field too
    assign rd_word = rd_slot[1] ? {16'h0000, reg_q[rd_slot[0]]} : 32'h0000_0000;

    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

    // the two range words
    genvar g;
    generate
        for (g = 0; g < `ARS_NUM_REGS; g++) begin : g_reg
            ars_range_cell #(
                .WIDTH(`ARS_REG_W),
                .RESET_VAL(`ARS_RANGE_RESET)
            ) u_cell (
                .aclk(aclk),
                .aresetn(aresetn),
                .ce(ce),
                .wr_en(wr_go && wr_slot[1] && (wr_slot[0] == 1'(g))),
                .wr_data(w_data_q),
                .wr_mask(wr_mask),
                .q(reg_q[g])
            );
        end
    endgenerate

    // write channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= '0;
            w_held_q <= 1'b0;
            w_data_q <= 16'h0000;
            w_strb_q <= 2'h0;
            bvalid_q <= 1'b0;
            bresp_q <= `ARS_RESP_OKAY;
        end else if (ce) begin
            if (aw_fire) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= awaddr;
            end
            if (w_fire) begin
                w_held_q <= 1'b1;
                w_data_q <= wdata[15:0];
                w_strb_q <= wstrb[1:0];
            end
            if (wr_go) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_slot[1] ? `ARS_RESP_OKAY : `ARS_RESP_SLVERR;
            end else if (bvalid_q && bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `ARS_RESP_OKAY;
        end else if (ce) begin
            if (ar_fire) begin
                rvalid_q <= 1'b1;
                rdata_q <= rd_word;
                rresp_q <= rd_slot[1] ? `ARS_RESP_OKAY : `ARS_RESP_SLVERR;
            end else if (rvalid_q && rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // decoded ranges; bit 8 and bits 15:9 never reach them
    always_ff @(posedge aclk) begin
        for (int i = 0; i < NCH; i++) begin
            if (!aresetn) begin
                range_q[i] <= ARS_RNG_10V;
            end else if (ce) begin
                range_q[i] <= decode_range(reg_q[i / 4][(i % 4) * 2 +: 2]);
            end
        end
    end

    assign range_chan_a_in0 = range_q[0];
    assign range_chan_a_in1 = range_q[1];
    assign range_chan_a_in2 = range_q[2];
    assign range_chan_a_in3 = range_q[3];
    assign range_chan_a_in4 = range_q[4];
    assign range_chan_a_in5 = range_q[5];
    assign range_chan_a_in6 = range_q[6];
    assign range_chan_a_in7 = range_q[7];

    // checks
    low_reset_val_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(!aresetn) |-> reg_q[0] == `ARS_RANGE_RESET)
        else $error("low range register wrong after reset");

    high_reset_val_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(!aresetn) |-> reg_q[1] == `ARS_RANGE_RESET)
        else $error("high range register wrong after reset");

    addr_field_rw_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go && wr_slot == 2'h3 && w_strb_q[1] |=> reg_q[1][15:9] == $past(w_data_q[15:9]))
        else $error("address field not stored");

    low_field_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce |=> range_q[3] == decode_range($past(reg_q[0][7:6]))
            && range_q[0] == decode_range($past(reg_q[0][1:0])))
        else $error("low register field mapping wrong");

    high_field_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce |=> range_q[7] == decode_range($past(reg_q[1][7:6]))
            && range_q[5] == decode_range($past(reg_q[1][3:2])))
        else $error("high register field mapping wrong");

    code_decode_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && reg_q[0][1:0] == 2'h1 && reg_q[0][3:2] == 2'h2 && reg_q[0][5:4] == 2'h0
        |=> range_q[0] == ARS_RNG_2V5 && range_q[1] == ARS_RNG_5V && range_q[2] == ARS_RNG_10V)
        else $error("range code decoded wrongly");

    field_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(!aresetn) |-> range_q[0] == ARS_RNG_10V && range_q[7] == ARS_RNG_10V)
        else $error("range not 10V after reset");

    low_write_back_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go && wr_slot == 2'h2 && w_strb_q == 2'h3 |=> reg_q[0] == $past(w_data_q))
        else $error("low register write lost");

    read_back_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ar_fire && rd_slot == 2'h2 |=> rvalid_q && rdata_q == {16'h0000, $past(reg_q[0])})
        else $error("read data differs from register");

    rsvd_bit_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && $past(ce) && $stable(reg_q[0][7:0]) && $changed(reg_q[0][15:8])
        |=> $stable(range_q[0]))
        else $error("upper bits changed a range");

    bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        bvalid_q && !bready |=> bvalid_q && $stable(bresp_q))
        else $error("write response dropped early");
endmodule // ars_range_bank

// *** design/ars_range_cell.sv ***
// one range register word with per-bit write mask
`timescale 1ns/1ps
`include "ars_regs.svh"
module ars_range_cell #(
    parameter int WIDTH = `ARS_REG_W,
    parameter logic [WIDTH-1:0] RESET_VAL = `ARS_RANGE_RESET
) (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // write port
    input wire logic wr_en,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [WIDTH-1:0] wr_mask,
    // stored value
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] word_q;
    logic [WIDTH-1:0] word_d;

    assign word_d = (word_q & ~wr_mask) | (wr_data & wr_mask);
    assign q = word_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            word_q <= RESET_VAL;
        end else if (ce && wr_en) begin
            word_q <= word_d;
        end
    end
endmodule // ars_range_cell

// *** design/ars_regs.svh ***
// offsets, field positions and reset values of the channel-a range registers
`ifndef ARS_REGS_SVH
`define ARS_REGS_SVH

// register indices; the bus byte address is four times the index
`define ARS_IDX_RANGE_A_LOW 6'h04
`define ARS_IDX_RANGE_A_HIGH 6'h05
`define ARS_NUM_REGS 2
`define ARS_REG_W 16
`define ARS_RANGE_RESET 16'h00ff
`define ARS_ADDR_FIELD_MSB 15
`define ARS_ADDR_FIELD_LSB 9
`define ARS_ADDR_FIELD_RESET 7'h00
`define ARS_RSVD_BIT 8
`define ARS_FIELD_W 2
`define ARS_FIELDS_PER_REG 4
`define ARS_FIELD_RESET 2'h3
`define ARS_RESP_OKAY 2'h0
`define ARS_RESP_SLVERR 2'h2

`endif

// *** test/ars_host_model.sv ***
// host-side axi4-lite master for the range register bank
`timescale 1ns/1ps
module ars_host_model (
    // clock
    input wire logic aclk,
    // write side
    output logic awvalid,
    input wire logic awready,
    output logic [7:0] awaddr,
    output logic wvalid,
    input wire logic wready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    input wire logic bvalid,
    output logic bready,
    input wire logic [1:0] bresp,
    // read side
    output logic arvalid,
    input wire logic arready,
    output logic [7:0] araddr,
    input wire logic rvalid,
    output logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    // set when an answer never came
    output logic hang
);
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, hang} = '0;
        {awaddr, wdata, wstrb, araddr} = '0;
    end
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        int n;
        logic [3:0] hs;
        n = 0;
        r = 'x;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {16'h0, d[15:9], 1'b0, d[7:0]};
        wstrb <= s;
        {awvalid, wvalid} <= 2'h3;
        // bready rises only once bvalid is seen, so the response must hold a cycle
        while (n < 50) begin
            @(negedge aclk);
            hs = {awvalid & awready, wvalid & wready, bvalid, bvalid & bready};
            r = bresp;
            @(posedge aclk);
            n++;
            if (hs[0]) break;
            if (hs[3]) awvalid <= 1'b0;
            if (hs[2]) wvalid <= 1'b0;
            if (hs[1]) bready <= 1'b1;
        end
        bready <= 1'b0;
        if (!hs[0]) hang <= 1'b1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        logic [1:0] hs;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        while (n < 50) begin
            @(negedge aclk);
            hs = {arvalid & arready, rvalid};
            d = rdata;
            r = rresp;
            @(posedge aclk);
            n++;
            if (hs[0]) break;
            if (hs[1]) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        if (!hs[0]) hang <= 1'b1;
    endtask
endmodule // ars_host_model

// *** test/tb_ars_range_bank.sv ***
// self-checking bench for the channel-a range register bank
`timescale 1ns/1ps
`include "ars_regs.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb_ars_range_bank;
    import ars_pkg::*;
    logic aclk, aresetn, ce, hang, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, lfsr, d;
    logic [3:0] wstrb, s;
    logic [1:0] bresp, rresp, rs;
    logic [15:0] w;
    logic [15:0] shadow [2];
    wire ars_range_e rng [8];
    int fail_count, total_checks, r;
    ars_range_bank ars_range_bank_inst (.aclk, .aresetn, .ce, .awvalid, .awready, .awaddr,
        .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
        .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp,
        .range_chan_a_in0(rng[0]), .range_chan_a_in1(rng[1]), .range_chan_a_in2(rng[2]),
        .range_chan_a_in3(rng[3]), .range_chan_a_in4(rng[4]), .range_chan_a_in5(rng[5]),
        .range_chan_a_in6(rng[6]), .range_chan_a_in7(rng[7]));
    ars_host_model ars_host_model_inst (.aclk, .awvalid, .awready, .awaddr, .wvalid, .wready,
        .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
        .rready, .rdata, .rresp, .hang);
    function automatic ars_range_e exp_rng(logic [1:0] c);
        return c == 2'h1 ? ARS_RNG_2V5 : (c == 2'h2 ? ARS_RNG_5V : ARS_RNG_10V);
    endfunction
    function automatic logic [31:0] lfsr_next(logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [7:0] addr(int i);
        return 8'((`ARS_IDX_RANGE_A_LOW + i) * 4);
    endfunction
    task automatic check_all();
        for (int i = 0; i < 2; i++) begin
            ars_host_model_inst.rd(addr(i), d, rs);
            `CHK("rresp", 2'h0, rs)
            `CHK("rdata", {16'h0, shadow[i]}, d)
        end
        @(negedge aclk);
        for (int i = 0; i < 8; i++) begin
            `CHK("range", exp_rng(shadow[i/4][2*(i%4)+:2]), rng[i])
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    always @(posedge hang) begin
        fail_count++;
        conclude();
    end
    initial begin
        aresetn = 1'b0;
        ce = 1'b1;
        lfsr = 32'd87674;
        shadow = '{`ARS_RANGE_RESET, `ARS_RANGE_RESET};
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        check_all();
        $display("test reset done");
        for (int c = 0; c < 4; c++) begin
            for (int i = 0; i < 2; i++) begin
                w = {7'(c * 9 + i), 1'b0, {4{c[1:0]}}};
                ars_host_model_inst.wr(addr(i), w, 4'hf, rs);
                `CHK("bresp", 2'h0, rs)
                shadow[i] = w;
            end
            check_all();
        end
        $display("test codes done");
        repeat (24) begin
            lfsr = lfsr_next(lfsr);
            r = int'(lfsr[5]);
            w = lfsr[31:16] & 16'hfeff;
            s = lfsr[3:0];
            ars_host_model_inst.wr(addr(r), w, s, rs);
            if (s[0]) shadow[r][7:0] = w[7:0];
            if (s[1]) shadow[r][15:8] = w[15:8];
            check_all();
        end
        $display("test random done");
        ars_host_model_inst.wr(addr(0), 16'h0009, 4'hf, rs);
        `CHK("bresp", 2'h0, rs)
        shadow[0] = 16'h0009;
        check_all();
        ars_host_model_inst.wr(addr(0), 16'ha400, 4'h2, rs);
        `CHK("bresp", 2'h0, rs)
        shadow[0][15:8] = 8'ha4;
        check_all();
        $display("test corner done");
        ars_host_model_inst.wr(8'h18, 16'h1234, 4'hf, rs);
        `CHK("bresp", 2'h2, rs)
        ars_host_model_inst.rd(8'h18, d, rs);
        `CHK("rresp", 2'h2, rs)
        `CHK("rdata", 32'h0, d)
        check_all();
        $display("test unmapped done");
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        shadow = '{`ARS_RANGE_RESET, `ARS_RANGE_RESET};
        check_all();
        $display("test second reset done");
        conclude();
    end
endmodule // tb_ars_range_bank
